// file: rtl/dccl_pkg.sv
// package: latch bank addresses, field positions and reset values
package dccl_pkg;
  localparam int unsigned DATA_W = 7;
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] ADDR_A_STATIC_0 = 3'h0;
  localparam logic [2:0] ADDR_A_STATIC_1 = 3'h1;
  localparam logic [2:0] ADDR_A_DYNAMIC = 3'h2;
  localparam logic [2:0] ADDR_TEST_0 = 3'h3;
  localparam logic [2:0] ADDR_TEST_1 = 3'h4;
  localparam logic [2:0] ADDR_B_STATIC_0 = 3'h5;
  localparam logic [2:0] ADDR_B_STATIC_1 = 3'h6;
  localparam logic [2:0] ADDR_B_DYNAMIC = 3'h7;
  // static bank 0 fields
  localparam int unsigned BIT_RX_RATE = 0;
  // static bank 1 fields
  localparam int unsigned BIT_TRG_RATE = 0;
  localparam int unsigned BIT_PRI_DET_LO = 3;
  localparam int unsigned BIT_SEC_DET_LO = 5;
  // dynamic bank fields
  localparam int unsigned BIT_ROE1 = 1;
  localparam int unsigned BIT_ROE2 = 2;
  localparam int unsigned BIT_TEST_SEL0 = 4;
  localparam int unsigned BIT_RX_POWER = 5;
  localparam int unsigned BIT_TEST_SEL1 = 6;
  // reset values of the functional bits
  localparam logic RST_RX_RATE = 1'b1;
  localparam logic RST_TRG_RATE = 1'b0;
  localparam logic [1:0] RST_DET_LEVEL = 2'h2;
  localparam logic RST_RX_POWER = 1'b0;
  localparam logic RST_ROE = 1'b0;
  localparam logic [1:0] RST_TEST_SEL = 2'h3;
  // detect level coding
  localparam logic [1:0] DET_OFF = 2'h0;
  localparam logic [1:0] DET_140MV = 2'h1;
  localparam logic [1:0] DET_280MV = 2'h2;
  localparam logic [1:0] DET_420MV = 2'h3;
  // test select coding
  localparam logic [1:0] TSEL_NORMAL = 2'h1;
  localparam logic [1:0] TSEL_PATTERN = 2'h2;
endpackage : dccl_pkg

// file: rtl/dccl_config_latches.sv
// dual channel configuration latch bank with power control outputs
//////////////////////////////////////////////////////////////////////////////
module dccl_config_latches (
  input wire logic clk,
  input wire logic rst,
  input wire logic config_write_strobe_n,
  input wire logic [dccl_pkg::ADDR_W-1:0] config_addr,
  input wire logic [dccl_pkg::DATA_W-1:0] config_data,
  output logic [1:0] rx_clock_half_rate_sel,
  output logic [1:0] training_clock_double,
  output logic [3:0] primary_detect_level,
  output logic [3:0] secondary_detect_level,
  output logic [1:0] primary_detector_enable,
  output logic [1:0] secondary_detector_enable,
  output logic [1:0] rx_channel_power_on,
  output logic [3:0] rx_test_select,
  output logic [1:0] rx_normal_mode,
  output logic [1:0] rx_pattern_mode,
  output logic [1:0] rx_test_select_invalid,
  output logic [1:0] reclock_primary_drv_enable,
  output logic [1:0] reclock_secondary_drv_enable,
  output logic [1:0] tx_primary_out_enable,
  output logic [1:0] tx_secondary_out_enable,
  output logic [1:0] primary_driver_power_on,
  output logic [1:0] secondary_driver_power_on,
  output logic [1:0] reclock_logic_power_on,
  output logic [1:0] deserializer_power_on,
  output logic [13:0] test_bank_value
);
  import dccl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers: the port comes from an outside host
  logic strobe_s1_q, strobe_s2_q, strobe_s1_d, strobe_s2_d;
  logic [ADDR_W-1:0] addr_s1_q, addr_s2_q, addr_s1_d, addr_s2_d;
  logic [DATA_W-1:0] data_s1_q, data_s2_q, data_s1_d, data_s2_d;

  always_comb begin
    strobe_s1_d = config_write_strobe_n;
    strobe_s2_d = strobe_s1_q;
    addr_s1_d = config_addr;
    addr_s2_d = addr_s1_q;
    data_s1_d = config_data;
    data_s2_d = data_s1_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      strobe_s1_q <= 1'b1;
      strobe_s2_q <= 1'b1;
      addr_s1_q <= '0;
      addr_s2_q <= '0;
      data_s1_q <= '0;
      data_s2_q <= '0;
    end else begin
      strobe_s1_q <= strobe_s1_d;
      strobe_s2_q <= strobe_s2_d;
      addr_s1_q <= addr_s1_d;
      addr_s2_q <= addr_s2_d;
      data_s1_q <= data_s1_d;
      data_s2_q <= data_s2_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // latch banks, index 0 is channel A, 1 is channel B
  logic [1:0] rx_rate_q, rx_rate_d;
  logic [1:0] trg_rate_q, trg_rate_d;
  logic [1:0] pri_det_q [2];
  logic [1:0] pri_det_d [2];
  logic [1:0] sec_det_q [2];
  logic [1:0] sec_det_d [2];
  logic [1:0] rx_pwr_q, rx_pwr_d;
  logic [1:0] tsel_q [2];
  logic [1:0] tsel_d [2];
  logic [1:0] roe1_q, roe1_d;
  logic [1:0] roe2_q, roe2_d;
  logic [DATA_W-1:0] test_q [2];
  logic [DATA_W-1:0] test_d [2];
  logic wr;

  function automatic logic [2:0] bank_base(input logic ch);
    bank_base = ch ? ADDR_B_STATIC_0 : ADDR_A_STATIC_0;
  endfunction : bank_base

  always_comb begin
    wr = !strobe_s2_q;
    rx_rate_d = rx_rate_q;
    trg_rate_d = trg_rate_q;
    rx_pwr_d = rx_pwr_q;
    roe1_d = roe1_q;
    roe2_d = roe2_q;
    for (int c = 0; c < 2; c++) begin
      pri_det_d[c] = pri_det_q[c];
      sec_det_d[c] = sec_det_q[c];
      tsel_d[c] = tsel_q[c];
      test_d[c] = test_q[c];
    end
    if (wr) begin // no read path, banks are write-only
      for (int c = 0; c < 2; c++) begin
        // static banks, two per channel
        if (addr_s2_q == bank_base(c[0])) begin
          rx_rate_d[c] = data_s2_q[BIT_RX_RATE];
        end
        if (addr_s2_q == 3'(bank_base(c[0]) + 3'h1)) begin
          trg_rate_d[c] = data_s2_q[BIT_TRG_RATE];
          pri_det_d[c] = data_s2_q[BIT_PRI_DET_LO +: 2];
          sec_det_d[c] = data_s2_q[BIT_SEC_DET_LO +: 2];
        end
        // dynamic bank
        if (addr_s2_q == 3'(bank_base(c[0]) + 3'h2)) begin
          roe1_d[c] = data_s2_q[BIT_ROE1];
          roe2_d[c] = data_s2_q[BIT_ROE2];
          rx_pwr_d[c] = data_s2_q[BIT_RX_POWER];
          tsel_d[c] = {data_s2_q[BIT_TEST_SEL1], data_s2_q[BIT_TEST_SEL0]};
        end
      end
      // internal test registers, outside channel configuration
      if (addr_s2_q == ADDR_TEST_0) begin
        test_d[0] = data_s2_q;
      end
      if (addr_s2_q == ADDR_TEST_1) begin
        test_d[1] = data_s2_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_rate_q <= {2{RST_RX_RATE}};
      trg_rate_q <= {2{RST_TRG_RATE}};
      rx_pwr_q <= {2{RST_RX_POWER}};
      roe1_q <= {2{RST_ROE}};
      roe2_q <= {2{RST_ROE}};
      for (int c = 0; c < 2; c++) begin
        pri_det_q[c] <= RST_DET_LEVEL;
        sec_det_q[c] <= RST_DET_LEVEL;
        tsel_q[c] <= RST_TEST_SEL;
        test_q[c] <= '0;
      end
    end else begin
      rx_rate_q <= rx_rate_d;
      trg_rate_q <= trg_rate_d;
      rx_pwr_q <= rx_pwr_d;
      roe1_q <= roe1_d;
      roe2_q <= roe2_d;
      for (int c = 0; c < 2; c++) begin
        pri_det_q[c] <= pri_det_d[c];
        sec_det_q[c] <= sec_det_d[c];
        tsel_q[c] <= tsel_d[c];
        test_q[c] <= test_d[c];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered control outputs derived from the next latch values
  logic [1:0] half_q, trg_o_q, pde_q, sde_q, pwr_q, nrm_q, pat_q, inv_q;
  logic [1:0] r1_q, r2_q, t1_q, t2_q, p1_q, p2_q, rcl_q, des_q;
  logic [3:0] pdl_q, sdl_q, tso_q;
  logic [13:0] tbv_q;
  logic [1:0] half_d, trg_o_d, pde_d, sde_d, pwr_d, nrm_d, pat_d, inv_d;
  logic [1:0] r1_d, r2_d, t1_d, t2_d, p1_d, p2_d, rcl_d, des_d;
  logic [3:0] pdl_d, sdl_d, tso_d;
  logic [13:0] tbv_d;

  always_comb begin
    half_d = rx_rate_d;
    trg_o_d = trg_rate_d;
    pwr_d = rx_pwr_d;
    r1_d = roe1_d;
    r2_d = roe2_d;
    t1_d = roe1_d;
    t2_d = roe2_d;
    p1_d = roe1_d;
    p2_d = roe2_d;
    rcl_d = roe1_d | roe2_d;
    des_d = rx_pwr_d;
    tbv_d = {test_d[1], test_d[0]};
    for (int c = 0; c < 2; c++) begin
      pdl_d[2*c +: 2] = pri_det_d[c];
      sdl_d[2*c +: 2] = sec_det_d[c];
      pde_d[c] = pri_det_d[c] != DET_OFF;
      sde_d[c] = sec_det_d[c] != DET_OFF;
      tso_d[2*c +: 2] = tsel_d[c];
      nrm_d[c] = tsel_d[c] == TSEL_NORMAL;
      pat_d[c] = tsel_d[c] == TSEL_PATTERN;
      inv_d[c] = !(nrm_d[c] || pat_d[c]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      half_q <= {2{RST_RX_RATE}};
      trg_o_q <= {2{RST_TRG_RATE}};
      pwr_q <= {2{RST_RX_POWER}};
      r1_q <= '0;
      r2_q <= '0;
      t1_q <= '0;
      t2_q <= '0;
      p1_q <= '0;
      p2_q <= '0;
      rcl_q <= '0;
      des_q <= '0;
      pdl_q <= {2{RST_DET_LEVEL}};
      sdl_q <= {2{RST_DET_LEVEL}};
      pde_q <= 2'h3;
      sde_q <= 2'h3;
      tso_q <= {2{RST_TEST_SEL}};
      nrm_q <= '0;
      pat_q <= '0;
      inv_q <= 2'h3;
      tbv_q <= '0;
    end else begin
      half_q <= half_d;
      trg_o_q <= trg_o_d;
      pwr_q <= pwr_d;
      r1_q <= r1_d;
      r2_q <= r2_d;
      t1_q <= t1_d;
      t2_q <= t2_d;
      p1_q <= p1_d;
      p2_q <= p2_d;
      rcl_q <= rcl_d;
      des_q <= des_d;
      pdl_q <= pdl_d;
      sdl_q <= sdl_d;
      pde_q <= pde_d;
      sde_q <= sde_d;
      tso_q <= tso_d;
      nrm_q <= nrm_d;
      pat_q <= pat_d;
      inv_q <= inv_d;
      tbv_q <= tbv_d;
    end
  end

  assign rx_clock_half_rate_sel = half_q;
  assign training_clock_double = trg_o_q;
  assign rx_channel_power_on = pwr_q;
  assign reclock_primary_drv_enable = r1_q;
  assign reclock_secondary_drv_enable = r2_q;
  assign tx_primary_out_enable = t1_q;
  assign tx_secondary_out_enable = t2_q;
  assign primary_driver_power_on = p1_q;
  assign secondary_driver_power_on = p2_q;
  assign reclock_logic_power_on = rcl_q;
  assign deserializer_power_on = des_q;
  assign primary_detect_level = pdl_q;
  assign secondary_detect_level = sdl_q;
  assign primary_detector_enable = pde_q;
  assign secondary_detector_enable = sde_q;
  assign rx_test_select = tso_q;
  assign rx_normal_mode = nrm_q;
  assign rx_pattern_mode = pat_q;
  assign rx_test_select_invalid = inv_q;
  assign test_bank_value = tbv_q;
endmodule : dccl_config_latches

// file: verification/dccl_config_latches_chk.sv
// checker: reset, power and write properties of the configuration latch bank
module dccl_config_latches_chk
  import dccl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic config_write_strobe_n,
  input wire logic [dccl_pkg::ADDR_W-1:0] config_addr,
  input wire logic [dccl_pkg::DATA_W-1:0] config_data,
  input wire logic [1:0] rx_clock_half_rate_sel,
  input wire logic [3:0] primary_detect_level,
  input wire logic [1:0] primary_detector_enable,
  input wire logic [1:0] rx_channel_power_on,
  input wire logic [1:0] reclock_primary_drv_enable,
  input wire logic [1:0] reclock_secondary_drv_enable,
  input wire logic [1:0] tx_primary_out_enable,
  input wire logic [1:0] secondary_driver_power_on,
  input wire logic [1:0] reclock_logic_power_on,
  input wire logic [1:0] deserializer_power_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  sequence s_quiet;
    config_write_strobe_n [*6];
  endsequence
  sequence s_power_write;
    (!config_write_strobe_n && config_addr == ADDR_A_DYNAMIC && config_data[BIT_RX_POWER]) [*2];
  endsequence
  property p_reset_init;
    disable iff (1'b0) rst |=> rx_channel_power_on == 2'h0 && reclock_primary_drv_enable == 2'h0
      && rx_clock_half_rate_sel == 2'h3 && primary_detect_level == 4'hA;
  endproperty
  property p_deser_power;
    deserializer_power_on == rx_channel_power_on;
  endproperty
  property p_reclock_logic;
    reclock_logic_power_on == (reclock_primary_drv_enable | reclock_secondary_drv_enable);
  endproperty
  property p_tx_follow;
    tx_primary_out_enable == reclock_primary_drv_enable;
  endproperty
  property p_driver_power;
    secondary_driver_power_on == reclock_secondary_drv_enable;
  endproperty
  property p_detect_enable;
    primary_detector_enable == {primary_detect_level[3:2] != 2'h0, primary_detect_level[1:0] != 2'h0};
  endproperty
  property p_hold;
    s_quiet |=> $stable(rx_channel_power_on) && $stable(primary_detect_level);
  endproperty
  property p_power_write;
    s_power_write |-> ##[1:6] rx_channel_power_on[0];
  endproperty
  a_reset_init: assert property (p_reset_init)
    else $error("latch reset values wrong");
  a_deser_power: assert property (p_deser_power)
    else $error("deserializer power differs");
  a_reclock_logic: assert property (p_reclock_logic)
    else $error("reclock logic power wrong");
  a_tx_follow: assert property (p_tx_follow)
    else $error("tx enable does not follow latch");
  a_driver_power: assert property (p_driver_power)
    else $error("driver power does not follow latch");
  a_detect_enable: assert property (p_detect_enable)
    else $error("detector enable wrong");
  a_hold: assert property (p_hold)
    else $error("latch changed without write");
  a_power_write: assert property (p_power_write)
    else $error("power write not taken");
endmodule : dccl_config_latches_chk
bind dccl_config_latches dccl_config_latches_chk u_chk (.*);

// file: verification/dccl_host_model.sv
// host model: drives strobed configuration writes
module dccl_host_model
  import dccl_pkg::*;
(
  input wire logic clk,
  output logic config_write_strobe_n,
  output logic [dccl_pkg::ADDR_W-1:0] config_addr,
  output logic [dccl_pkg::DATA_W-1:0] config_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    config_write_strobe_n = 1'b1;
    config_addr = 3'h0;
    config_data = 7'h00;
  end
  // no handshake: setup and strobe width follow the sync depth
  task automatic put(input logic [2:0] a, input logic [6:0] d, output logic [6:0] sent);
    sent = (a == ADDR_A_STATIC_0 || a == ADDR_B_STATIC_0) ? {2'b10, d[4:3], 2'b00, d[0]} : d;
    @(posedge clk);
    config_addr <= a;
    config_data <= sent;
    repeat (3) @(posedge clk);
    config_write_strobe_n <= 1'b0;
    repeat (2) @(posedge clk);
    config_write_strobe_n <= 1'b1;
    @(posedge clk);
    config_data <= ~sent; // released bus shows no stale value
  endtask : put
endmodule : dccl_host_model

// file: verification/dccl_config_latches_tb_top.sv
// testbench: host writes every bank, decoded outputs are scored
module dccl_config_latches_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dccl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strobe_n;
  logic [2:0] addr;
  logic [6:0] data;
  logic [1:0] rt, tg, pe, se, pw, nm, pt, iv, o1, o2, rl;
  logic [3:0] pd, sd, ts;
  logic [13:0] tv;
  logic [1:0] tx1, tx2, dp1, dp2, ds;
  logic [6:0] bank [8];
  logic [57:0] q [$];
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  event seen_ev;
  initial begin
    forever #4 clk = ~clk;
  end
  dccl_host_model host (.clk(clk), .config_write_strobe_n(strobe_n), .config_addr(addr), .config_data(data));
  dccl_config_latches DUT (
    .clk(clk), .rst(rst), .config_write_strobe_n(strobe_n), .config_addr(addr), .config_data(data),
    .rx_clock_half_rate_sel(rt), .training_clock_double(tg), .primary_detect_level(pd),
    .secondary_detect_level(sd), .primary_detector_enable(pe), .secondary_detector_enable(se),
    .rx_channel_power_on(pw), .rx_test_select(ts), .rx_normal_mode(nm), .rx_pattern_mode(pt),
    .rx_test_select_invalid(iv), .reclock_primary_drv_enable(o1), .reclock_secondary_drv_enable(o2),
    .tx_primary_out_enable(tx1), .tx_secondary_out_enable(tx2), .primary_driver_power_on(dp1),
    .secondary_driver_power_on(dp2), .reclock_logic_power_on(rl), .deserializer_power_on(ds),
    .test_bank_value(tv));
  ////////////////////////////////////////////////////////////
  function automatic logic [57:0] expect_obs();
    logic [1:0] xrt, xtg, xpe, xse, xpw, xnm, xpt, xiv, xo1, xo2, xrl;
    logic [3:0] xpd, xsd, xts;
    logic [6:0] s0, s1, dy;
    for (int c = 0; c < 2; c++) begin
      s0 = bank[c*5];
      s1 = bank[c*5+1];
      dy = bank[c*5+2];
      xrt[c] = s0[0];
      xtg[c] = s1[0];
      xpd[c*2+:2] = s1[4:3];
      xsd[c*2+:2] = s1[6:5];
      xpe[c] = s1[4:3] != 2'h0;
      xse[c] = s1[6:5] != 2'h0;
      xpw[c] = dy[5];
      xts[c*2+:2] = {dy[6], dy[4]};
      xnm[c] = {dy[6], dy[4]} == TSEL_NORMAL;
      xpt[c] = {dy[6], dy[4]} == TSEL_PATTERN;
      xiv[c] = !(xnm[c] | xpt[c]);
      xo1[c] = dy[1];
      xo2[c] = dy[2];
      xrl[c] = dy[1] | dy[2];
    end
    // tx enables and driver power follow the drive enables, deserializer follows rx power
    return {xo1, xo2, xo1, xo2, xpw,
            xrt, xtg, xpd, xsd, xpe, xse, xpw, xts, xnm, xpt, xiv, xo1, xo2, xrl, bank[4], bank[3]};
  endfunction : expect_obs
  task automatic check(input logic [57:0] seen, input logic [57:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic note();
    q.push_back(expect_obs());
    repeat (6) @(posedge clk);
    -> seen_ev;
  endtask : note
  task automatic wr(input logic [2:0] a, input logic [6:0] d);
    logic [6:0] s;
    host.put(a, d, s);
    bank[a] = s;
    note();
  endtask : wr
  task automatic do_reset();
    rst <= 1'b1; // device reset; no test-access port exists here
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bank = '{7'h01, 7'h50, 7'h50, 7'h00, 7'h00, 7'h01, 7'h50, 7'h50};
    note();
  endtask : do_reset
  ////////////////////////////////////////////////////////////
  initial begin
    logic [57:0] obs;
    forever begin
      @(seen_ev);
      #1;
      obs = {tx1, tx2, dp1, dp2, ds, rt, tg, pd, sd, pe, se, pw, ts, nm, pt, iv, o1, o2, rl, tv};
      check(obs, q.pop_front());
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    logic [1:0] k;
    void'($urandom(59150));
    @(posedge clk);
    do_reset();
    wr(ADDR_A_DYNAMIC, 7'h30);
    wr(ADDR_B_DYNAMIC, 7'h30);
    wr(ADDR_A_STATIC_0, 7'h00);
    wr(ADDR_A_STATIC_0, 7'h01);
    wr(ADDR_B_STATIC_0, 7'h00);
    wr(ADDR_TEST_0, 7'h5A);
    wr(ADDR_TEST_1, 7'h25);
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      wr(ADDR_B_STATIC_1, {k, k, 3'h1});
      wr(ADDR_A_DYNAMIC, {k[1], 1'b0, k[0], 1'b0, k[0], k[1], 1'b0});
    end
    repeat (24) wr(3'($urandom_range(7, 0)), 7'($urandom));
    do_reset();
    // let the watcher score the last note before the verdict
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule : dccl_config_latches_tb_top
